// File: sg_ring_regs.svh
// register offsets, field positions and reset values of the descriptor ring
`ifndef SG_RING_REGS_SVH
`define SG_RING_REGS_SVH

// apb byte offsets
`define OFS_CTRL         12'h000
`define OFS_ENGINE_NEXT  12'h004
`define OFS_HOST_SUBMIT  12'h008
`define OFS_LAST_DONE    12'h00C
`define OFS_IRQ_STATUS   12'h010
`define OFS_IRQ_MASK     12'h014
`define OFS_DESC_INDEX   12'h018
`define OFS_DESC_DATA    12'h01C
`define OFS_ENGINE_STATE 12'h020

// control register fields
`define CTRL_ENABLE_BIT  0
`define CTRL_DIR_BIT     1
`define CTRL_NCNT_LSB    8
`define CTRL_NCNT_MSB    15

// descriptor word fields
`define DESC_LEN_LSB     0
`define DESC_LEN_MSB     15
`define DESC_FIRST_BIT   16
`define DESC_LAST_BIT    17
`define DESC_IRQ_BIT     18
`define DESC_DONE_BIT    19
`define DESC_USER_LSB    20
`define DESC_USER_MSB    27

// interrupt status fields
`define IRQ_PKT_BIT      0
`define IRQ_COUNT_BIT    1
`define IRQ_STALL_BIT    2

// reset values
`define CTRL_RST         32'h0000_0000
`define IRQ_MASK_RST     3'h0
`define PTR_RST          11'h000

// descriptors in one ring
`define RING_DESC_COUNT  1999

`endif

// File: sg_ring_pkg.sv
// types shared by the descriptor ring engine
package sg_ring_pkg;

   typedef logic [10:0] desc_ptr_t;
   typedef logic [15:0] len_t;
   typedef logic [7:0]  user_t;

   typedef enum logic [1:0]
   {
      st_idle = 2'b00,
      st_load = 2'b01,
      st_xfer = 2'b10,
      st_wb   = 2'b11
   } engine_state_e;

   typedef enum logic
   {
      host_to_card_direction = 1'b0,
      card_to_host_direction = 1'b1
   } dma_dir_e;

endpackage : sg_ring_pkg

// File: sg_desc_mem.sv
// dual-port descriptor memory with registered read data
`timescale 1ns/1ps

module sg_desc_mem
#(
   parameter int WIDTH  = 32,
   parameter int ADDR_W = 11
)
(
   // clock
   input  wire logic              sys_clk,
   // port a
   input  wire logic [ADDR_W-1:0] a_addr,
   input  wire logic              a_we,
   input  wire logic [WIDTH-1:0]  a_wdata,
   output logic      [WIDTH-1:0]  a_rdata,
   // port b
   input  wire logic [ADDR_W-1:0] b_addr,
   input  wire logic              b_we,
   input  wire logic [WIDTH-1:0]  b_wdata,
   output logic      [WIDTH-1:0]  b_rdata
);

   logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

   // port b is written last, so the engine wins a same-address clash
   always_ff @(posedge sys_clk)
   begin
      if (a_we)
         mem[a_addr] <= a_wdata;
      if (b_we)
         mem[b_addr] <= b_wdata;
   end

   always_ff @(posedge sys_clk)
   begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
   end

endmodule : sg_desc_mem

// File: sg_dma_descriptor_ring.sv
// descriptor ring engine for one scatter-gather dma channel, apb registers
//
// Contract
// - completion pointer holds last finished descriptor
// - engine-next pointer advances as descriptors taken
// - software writes submit pointer; earlier descriptors owned
// - host supplies, engine consumes, independently on ring
// - first, last, interrupt markers honoured on transmit
// - user control passed along to card logic
// - write back done, first, last status
// - receive writes back actual packet length; code writes back the smaller of it and the supplied buffer length
// - receive writes back first, last, user status
// - notify software as each packet finishes; code only when its last descriptor has the interrupt flag
// - interrupt after every N processed descriptors
`timescale 1ns/1ps
`include "sg_ring_regs.svh"

module sg_dma_descriptor_ring
#(
   parameter int RING_SIZE = `RING_DESC_COUNT
)
(
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // interrupt
   output logic                    irq,
   // transmit towards card logic
   output logic                    tx_valid,
   input  wire logic               tx_ready,
   output sg_ring_pkg::len_t       tx_len,
   output logic                    tx_first,
   output logic                    tx_last,
   output sg_ring_pkg::user_t      tx_user_ctrl,
   // receive from card logic
   input  wire logic               rx_valid,
   output logic                    rx_ready,
   input  wire sg_ring_pkg::len_t  rx_len,
   input  wire logic               rx_first,
   input  wire logic               rx_last,
   input  wire sg_ring_pkg::user_t rx_user_status
);
   import sg_ring_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state

   engine_state_e state;
   desc_ptr_t     engine_next_desc_ptr;
   desc_ptr_t     host_submit_desc_ptr;
   desc_ptr_t     last_done_desc_ptr;
   desc_ptr_t     cur_idx;
   desc_ptr_t     desc_index;
   logic [31:0]   ctrl;
   logic [31:0]   cur_word;
   logic [31:0]   wb_word;
   logic [2:0]    irq_status;
   logic [2:0]    irq_mask;
   logic [7:0]    done_count;
   logic [31:0]   mem_a_rdata;
   logic [31:0]   mem_b_rdata;
   logic          stalled;

   logic          enable;
   dma_dir_e      dir;
   logic [7:0]    every_n;
   logic          apb_access;
   logic          apb_done;
   logic          apb_wr;
   logic          take_desc;
   logic          count_hit;
   logic          pkt_event;
   logic          stall_event;
   desc_ptr_t     mem_b_addr;
   logic          mem_b_we;
   logic [2:0]    next_status;

   assign enable     = ctrl[`CTRL_ENABLE_BIT];
   assign dir        = dma_dir_e'(ctrl[`CTRL_DIR_BIT]);
   assign every_n    = ctrl[`CTRL_NCNT_MSB:`CTRL_NCNT_LSB];
   assign apb_access = psel & penable & ~pready;
   assign apb_done   = psel & penable & pready;
   assign apb_wr     = apb_done & pwrite;

   function automatic desc_ptr_t ring_step(input desc_ptr_t p);
      if (p == desc_ptr_t'(RING_SIZE - 1))
         return '0;
      return p + 11'h001;
   endfunction : ring_step

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction : hit

   // no work while the ring holds nothing submitted
   assign take_desc = (state == st_idle) && enable &&
                      (engine_next_desc_ptr != host_submit_desc_ptr);
   assign stall_event = (state == st_idle) && enable && !stalled &&
                        (engine_next_desc_ptr == host_submit_desc_ptr);

   ////////////////////////////////////////////////////////////////////////
   // descriptor memory

   assign mem_b_addr = (state == st_wb) ? cur_idx : engine_next_desc_ptr;
   assign mem_b_we   = (state == st_wb);

   sg_desc_mem #(.WIDTH(32), .ADDR_W(11)) u_desc_mem
   (
      .sys_clk (sys_clk),
      .a_addr  (desc_index),
      .a_we    (apb_wr && hit(paddr, `OFS_DESC_DATA)),
      .a_wdata (pwdata),
      .a_rdata (mem_a_rdata),
      .b_addr  (mem_b_addr),
      .b_we    (mem_b_we),
      .b_wdata (wb_word),
      .b_rdata (mem_b_rdata)
   );

   // done flag plus packet framing in the written-back word
   always_comb
   begin
      wb_word = cur_word;
      wb_word[`DESC_DONE_BIT] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // engine sequence

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         state <= st_idle;
      else
         case (state)
            st_idle: if (take_desc) state <= st_load;
            st_load: state <= st_xfer;
            st_xfer:
               if ((dir == host_to_card_direction) ? (tx_valid && tx_ready)
                                                   : (rx_valid && rx_ready))
                  state <= st_wb;
            st_wb:   state <= st_idle;
            default: state <= st_idle;
         endcase
   end

   // pointer moves on as soon as a descriptor is taken up
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         engine_next_desc_ptr <= `PTR_RST;
         cur_idx              <= `PTR_RST;
      end
      else if (take_desc)
      begin
         cur_idx              <= engine_next_desc_ptr;
         engine_next_desc_ptr <= ring_step(engine_next_desc_ptr);
      end
      else if (apb_wr && hit(paddr, `OFS_ENGINE_NEXT) && !enable &&
               state == st_idle)
         engine_next_desc_ptr <= pwdata[10:0];
   end

   // only software moves the submit pointer
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         host_submit_desc_ptr <= `PTR_RST;
      else if (apb_wr && hit(paddr, `OFS_HOST_SUBMIT))
         host_submit_desc_ptr <= pwdata[10:0];
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         last_done_desc_ptr <= `PTR_RST;
      else if (state == st_wb)
         last_done_desc_ptr <= cur_idx;
      else if (apb_wr && hit(paddr, `OFS_LAST_DONE))
         last_done_desc_ptr <= pwdata[10:0];
   end

   // received length is clipped to the supplied buffer
   // framing and user status from the card are kept
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         cur_word <= 32'h0000_0000;
      else if (state == st_load)
         cur_word <= mem_b_rdata & ~(32'h1 << `DESC_DONE_BIT);
      else if (state == st_xfer && rx_valid && rx_ready)
      begin
         cur_word[`DESC_LEN_MSB:`DESC_LEN_LSB] <=
            (rx_len < cur_word[`DESC_LEN_MSB:`DESC_LEN_LSB]) ?
            rx_len : cur_word[`DESC_LEN_MSB:`DESC_LEN_LSB];
         cur_word[`DESC_FIRST_BIT] <= rx_first;
         cur_word[`DESC_LAST_BIT]  <= rx_last;
         cur_word[`DESC_USER_MSB:`DESC_USER_LSB] <= rx_user_status;
      end
   end

   // transmit framing taken straight from the descriptor
   // user control travels with the packet
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_valid     <= 1'b0;
         tx_len       <= 16'h0000;
         tx_first     <= 1'b0;
         tx_last      <= 1'b0;
         tx_user_ctrl <= 8'h00;
      end
      else if (state == st_load && dir == host_to_card_direction)
      begin
         tx_valid     <= 1'b1;
         tx_len       <= mem_b_rdata[`DESC_LEN_MSB:`DESC_LEN_LSB];
         tx_first     <= mem_b_rdata[`DESC_FIRST_BIT];
         tx_last      <= mem_b_rdata[`DESC_LAST_BIT];
         tx_user_ctrl <= mem_b_rdata[`DESC_USER_MSB:`DESC_USER_LSB];
      end
      else if (tx_valid && tx_ready)
         tx_valid <= 1'b0;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rx_ready <= 1'b0;
      else if (state == st_load && dir == card_to_host_direction)
         rx_ready <= 1'b1;
      else if (rx_valid && rx_ready)
         rx_ready <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupts

   // count completions, event every N (zero turns it off)
   assign count_hit = (state == st_wb) && (every_n != 8'h00) &&
                      (done_count + 8'h01 == every_n);
   // a finished packet flagged for interrupt is reported at once
   assign pkt_event = (state == st_wb) && cur_word[`DESC_LAST_BIT] &&
                      cur_word[`DESC_IRQ_BIT];

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         done_count <= 8'h00;
      else if (count_hit)
         done_count <= 8'h00;
      else if (state == st_wb && every_n != 8'h00)
         done_count <= done_count + 8'h01;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         stalled <= 1'b0;
      else
         stalled <= (state == st_idle) && enable &&
                    (engine_next_desc_ptr == host_submit_desc_ptr);
   end

   // set wins over a write-one-to-clear in the same cycle
   always_comb
   begin
      next_status = irq_status;
      if (apb_wr && hit(paddr, `OFS_IRQ_STATUS))
         next_status = next_status & ~pwdata[2:0];
      next_status[`IRQ_PKT_BIT]   = next_status[`IRQ_PKT_BIT] | pkt_event;
      next_status[`IRQ_COUNT_BIT] = next_status[`IRQ_COUNT_BIT] | count_hit;
      next_status[`IRQ_STALL_BIT] = next_status[`IRQ_STALL_BIT] | stall_event;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_status <= 3'h0;
         irq        <= 1'b0;
      end
      else
      begin
         irq_status <= next_status;
         irq        <= |(next_status & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb registers, one wait state on every access

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl       <= `CTRL_RST;
         irq_mask   <= `IRQ_MASK_RST;
         desc_index <= `PTR_RST;
      end
      else if (apb_wr)
      begin
         if (hit(paddr, `OFS_CTRL))
            ctrl <= pwdata;
         else if (hit(paddr, `OFS_IRQ_MASK))
            irq_mask <= pwdata[2:0];
         else if (hit(paddr, `OFS_DESC_INDEX))
            desc_index <= pwdata[10:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= apb_access;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (apb_access)
         begin
            if (hit(paddr, `OFS_CTRL))
               prdata <= ctrl;
            else if (hit(paddr, `OFS_ENGINE_NEXT))
               prdata <= {21'h0, engine_next_desc_ptr};
            else if (hit(paddr, `OFS_HOST_SUBMIT))
               prdata <= {21'h0, host_submit_desc_ptr};
            else if (hit(paddr, `OFS_LAST_DONE))
               prdata <= {21'h0, last_done_desc_ptr};
            else if (hit(paddr, `OFS_IRQ_STATUS))
               prdata <= {29'h0, irq_status};
            else if (hit(paddr, `OFS_IRQ_MASK))
               prdata <= {29'h0, irq_mask};
            else if (hit(paddr, `OFS_DESC_INDEX))
               prdata <= {21'h0, desc_index};
            else if (hit(paddr, `OFS_DESC_DATA))
               prdata <= mem_a_rdata;
            else if (hit(paddr, `OFS_ENGINE_STATE))
               prdata <= {29'h0, stalled, state};
            else
               pslverr <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_tx_offer;
      tx_valid && !tx_ready;
   endsequence

   sequence s_wb_step;
      state == st_wb;
   endsequence

   a_stall_holds: assert property (
      (state == st_idle && engine_next_desc_ptr == host_submit_desc_ptr)
      |=> state == st_idle)
      else $error("engine left idle with no descriptor submitted");

   a_next_moves: assert property (
      take_desc |=> engine_next_desc_ptr ==
                    ring_step($past(engine_next_desc_ptr)) &&
                    cur_idx == $past(engine_next_desc_ptr) ##3
                    state != st_load)
      else $error("engine-next pointer did not advance");

   a_done_ptr: assert property (
      s_wb_step |=> last_done_desc_ptr == $past(cur_idx))
      else $error("completion pointer not updated");

   a_wb_done_bit: assert property (
      s_wb_step |-> mem_b_we && mem_b_addr == cur_idx &&
                    wb_word[`DESC_DONE_BIT] &&
                    wb_word[`DESC_LAST_BIT] == cur_word[`DESC_LAST_BIT])
      else $error("write-back missing done flag");

   a_rx_len_clip: assert property (
      (state == st_xfer && rx_valid && rx_ready)
      |=> cur_word[`DESC_LEN_MSB:`DESC_LEN_LSB] <= $past(rx_len) &&
          state == st_wb)
      else $error("received length not clipped or not written back");

   a_tx_frame_hold: assert property (
      s_tx_offer |=> tx_valid && $stable(tx_first) && $stable(tx_last) &&
                     $stable(tx_len))
      else $error("transmit offer changed before acceptance");

   a_tx_user_pass: assert property (
      tx_valid |-> tx_user_ctrl == cur_word[`DESC_USER_MSB:`DESC_USER_LSB])
      else $error("user control lost on transmit");

   a_pkt_irq: assert property (
      pkt_event |=> irq_status[`IRQ_PKT_BIT] &&
                    (irq || !$past(irq_mask[`IRQ_PKT_BIT])))
      else $error("packet completion not reported");

   a_count_irq: assert property (
      count_hit |=> irq_status[`IRQ_COUNT_BIT] && done_count == 8'h00)
      else $error("every-N interrupt not raised");

   a_submit_write: assert property (
      (apb_wr && hit(paddr, `OFS_HOST_SUBMIT))
      |=> host_submit_desc_ptr == $past(pwdata[10:0]))
      else $error("submit pointer write lost");

endmodule : sg_dma_descriptor_ring

// File: card_side_model.sv
// card-side stream partner: sinks transmit words, sources receive words
`timescale 1ns/1ps

module card_side_model
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // behaviour select
   input  wire logic        slow,
   input  wire logic [1:0]  rx_num,
   input  wire logic [25:0] rx_word0,
   input  wire logic [25:0] rx_word1,
   // transmit sink
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [15:0] tx_len,
   input  wire logic        tx_first,
   input  wire logic        tx_last,
   input  wire logic [7:0]  tx_user_ctrl,
   output logic [1:0]       tx_count,
   // receive source
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic [15:0]      rx_len,
   output logic             rx_first,
   output logic             rx_last,
   output logic [7:0]       rx_user_status
);

   logic [25:0] seen [0:3];
   logic [1:0]  stall_cnt;
   logic [1:0]  rx_sent;

   ////////////////////////////////////////////////////////////////////////
   // user control taken with packet
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_ready  <= 1'b0;
         stall_cnt <= 2'h0;
         tx_count  <= 2'h0;
      end
      else if (tx_valid && tx_ready)
      begin
         seen[tx_count] <= {tx_user_ctrl, tx_last, tx_first, tx_len};
         tx_count       <= tx_count + 2'h1;
         tx_ready       <= 1'b0;
      end
      else if (tx_valid)
      begin
         // slow mode holds the engine in its transfer state a while
         if (stall_cnt == (slow ? 2'h3 : 2'h0))
         begin
            tx_ready  <= 1'b1;
            stall_cnt <= 2'h0;
         end
         else
            stall_cnt <= stall_cnt + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // released lines show the inverse so a stale sample cannot pass
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_valid <= 1'b0;
         rx_sent  <= 2'h0;
         {rx_user_status, rx_last, rx_first, rx_len} <= 26'h0;
      end
      else if (rx_valid && rx_ready)
      begin
         rx_valid <= 1'b0;
         rx_sent  <= rx_sent + 2'h1;
         {rx_user_status, rx_last, rx_first, rx_len} <=
            ~{rx_user_status, rx_last, rx_first, rx_len};
      end
      else if (!rx_valid && rx_sent < rx_num)
      begin
         rx_valid <= 1'b1;
         {rx_user_status, rx_last, rx_first, rx_len} <=
            (rx_sent == 2'h0) ? rx_word0 : rx_word1;
      end
   end

endmodule : card_side_model

// File: tb.sv
// self-checking bench for the descriptor ring engine
`timescale 1ns/1ps
`include "sg_ring_regs.svh"

module tb;
   import sg_ring_pkg::*;

   logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        tx_valid, tx_ready, tx_first, tx_last;
   len_t        tx_len, rx_len;
   user_t       tx_user_ctrl, rx_user_status;
   logic        rx_valid, rx_ready, rx_first, rx_last, slow;
   logic [1:0]  rx_num, tx_count;
   logic [25:0] rx_word0, rx_word1;
   int          err_total, num_checks;

   sg_dma_descriptor_ring #(.RING_SIZE(8)) u_sg_dma_descriptor_ring (
      .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_len(tx_len),
      .tx_first(tx_first), .tx_last(tx_last), .tx_user_ctrl(tx_user_ctrl),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_len(rx_len),
      .rx_first(rx_first), .rx_last(rx_last),
      .rx_user_status(rx_user_status));

   card_side_model u_card_side_model (
      .sys_clk(sys_clk), .rst(rst), .slow(slow), .rx_num(rx_num),
      .rx_word0(rx_word0), .rx_word1(rx_word1), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_len(tx_len), .tx_first(tx_first),
      .tx_last(tx_last), .tx_user_ctrl(tx_user_ctrl), .tx_count(tx_count),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_len(rx_len),
      .rx_first(rx_first), .rx_last(rx_last),
      .rx_user_status(rx_user_status));

   always #25 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task stop_test;
      $display("comparisons %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   // one apb transfer; pready and the answer are taken at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic er);
      int n;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1)
      begin
         if (n == 40)
         begin
            err_total++;
            stop_test();
         end
         n++;
         @(posedge sys_clk);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task rd(input logic [11:0] a, output logic [31:0] d);
      logic e;
      apb(1'b0, a, 32'h0, d, e);
   endtask : rd

   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(d, exp);
   endtask : rdchk

   task set_desc(input logic [31:0] idx, input logic [31:0] w);
      wr(`OFS_DESC_INDEX, idx);
      wr(`OFS_DESC_DATA, w);
   endtask : set_desc

   task desc_chk(input logic [31:0] idx, input logic [31:0] exp);
      wr(`OFS_DESC_INDEX, idx);
      rdchk(`OFS_DESC_DATA, exp);
   endtask : desc_chk

   // polls the completion pointer; giving up counts as a mismatch
   task wait_done(input logic [31:0] exp);
      logic [31:0] d;
      int          n;
      for (n = 0; n < 60; n++)
      begin
         rd(`OFS_LAST_DONE, d);
         if (d === exp)
            break;
      end
      check(d, exp);
      if (n == 60)
         stop_test();
   endtask : wait_done

   ////////////////////////////////////////////////////////////////////////
   task t_reset_regs;
      logic [31:0] d;
      logic        e;
      rdchk(`OFS_CTRL, `CTRL_RST);
      rdchk(`OFS_IRQ_MASK, 32'h0);
      rdchk(`OFS_ENGINE_NEXT, 32'h0);
      rdchk(`OFS_HOST_SUBMIT, 32'h0);
      rdchk(`OFS_LAST_DONE, 32'h0);
      rdchk(`OFS_IRQ_STATUS, 32'h0);
      apb(1'b0, 12'h040, 32'h0, d, e);
      check({31'h0, e}, 32'h1);
      check(d, 32'h0);
      check({31'h0, irq}, 32'h0);
   endtask : t_reset_regs

   task t_transmit;
      logic [31:0] d;
      set_desc(32'h0, 32'h0001_0100);
      set_desc(32'h1, 32'h05A6_0080);
      wr(`OFS_ENGINE_NEXT, 32'h0);
      wr(`OFS_HOST_SUBMIT, 32'h2);
      wr(`OFS_LAST_DONE, 32'h0);
      wr(`OFS_IRQ_MASK, 32'h1);
      wr(`OFS_CTRL, 32'h1);
      wait_done(32'h1);
      check({30'h0, tx_count}, 32'h2);
      check({6'h0, u_card_side_model.seen[0]}, 32'h0001_0100);
      check({6'h0, u_card_side_model.seen[1]}, 32'h016A_0080);
      desc_chk(32'h0, 32'h0009_0100);
      desc_chk(32'h1, 32'h05AE_0080);
      rd(`OFS_IRQ_STATUS, d);
      check(d & 32'h1, 32'h1);
      check(d & 32'h4, 32'h4);
      check({31'h0, irq}, 32'h1);
      rdchk(`OFS_ENGINE_NEXT, 32'h2);
      // moving the engine pointer while enabled must be refused
      wr(`OFS_ENGINE_NEXT, 32'h5);
      rdchk(`OFS_ENGINE_NEXT, 32'h2);
      rd(`OFS_ENGINE_STATE, d);
      check(d & 32'h7, 32'h4);
      wr(`OFS_IRQ_STATUS, 32'h7);
      rdchk(`OFS_IRQ_STATUS, 32'h0);
      check({31'h0, irq}, 32'h0);
      check({30'h0, tx_count}, 32'h2);
   endtask : t_transmit

   task t_receive;
      logic [31:0] d;
      wr(`OFS_CTRL, 32'h0);
      set_desc(32'h2, 32'h0000_0040);
      set_desc(32'h3, 32'h0000_0040);
      wr(`OFS_HOST_SUBMIT, 32'h4);
      wr(`OFS_IRQ_MASK, 32'h2);
      @(posedge sys_clk);
      rx_num <= 2'h2;
      // every-2 count interrupt, receive direction, enabled
      wr(`OFS_CTRL, 32'h0000_0203);
      wait_done(32'h3);
      desc_chk(32'h2, 32'h03C9_0020);
      desc_chk(32'h3, 32'h000A_0040);
      rd(`OFS_IRQ_STATUS, d);
      check(d & 32'h2, 32'h2);
      check({31'h0, irq}, 32'h1);
      rdchk(`OFS_ENGINE_NEXT, 32'h4);
      check({30'h0, tx_count}, 32'h2);
      set_desc(32'h2, 32'h0000_0040);
      desc_chk(32'h2, 32'h0000_0040);
   endtask : t_receive

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk    = 1'b0;
      rst        = 1'b1;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 12'h000;
      pwdata     = 32'h0;
      slow       = 1'b1;
      rx_num     = 2'h0;
      rx_word0   = {8'h3C, 1'b0, 1'b1, 16'h0020};
      rx_word1   = {8'h00, 1'b1, 1'b0, 16'h0050};
      err_total  = 0;
      num_checks = 0;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset_regs();
      t_transmit();
      t_receive();
      stop_test();
   end

endmodule : tb
